// file: hdl/pas_pkg.sv
package pas_pkg;
  localparam int CHANNELS = 16;
  localparam int CH_W = 4;
  localparam int DATA_W = 12;
  localparam int CLK_MHZ = 125;
  localparam int NAP_STEPS = 4;
  // conversion time and acquisition times, in nanoseconds
  localparam int T_CONV_NS = 1625;
  localparam int T_ACQ0_NS = 375;
  localparam int T_ACQ1_NS = 2375;
  localparam int T_ACQ2_NS = 6375;
  localparam int T_ACQ3_NS = 14375;
  localparam int T_PULSE_NS = 1000;
  // least times round up to whole cycles
  localparam int CONV_CYC = (T_CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ0_CYC = (T_ACQ0_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ1_CYC = (T_ACQ1_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ2_CYC = (T_ACQ2_NS * CLK_MHZ + 999) / 1000;
  localparam int ACQ3_CYC = (T_ACQ3_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 12;
  // register byte offsets (APB)
  localparam logic [7:0] ADDR_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_CFG1 = 8'h04;
  localparam logic [7:0] ADDR_CHSEL0 = 8'h08;
  localparam logic [7:0] ADDR_CHSEL1 = 8'h0C;
  localparam logic [7:0] ADDR_THRESH = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_RESULT0 = 8'h40;
  // cfg0 fields
  localparam int B_MODE = 0;
  localparam int B_TRIG = 1;
  localparam int B_FLAG = 2;
  // cfg1 field: sample_rate_field
  localparam int B_RATE_LO = 0;
  // chsel0 bit 0/1: pair 0-1 / 2-3 differential; bits [15:0] of chsel1 enable
  localparam int B_DIFF01 = 0;
  localparam int B_DIFF23 = 1;
  localparam int B_SHIFT_BUSY = 0;
  localparam int B_RUNNING = 1;
  localparam logic [15:0] CHSEL_RESET = 16'h0000;
  localparam logic [31:0] CFG1_RESET = 32'h0000_0000;
  typedef enum logic [2:0] {
    PAS_IDLE  = 3'b000,
    PAS_ACQ   = 3'b001,
    PAS_CONV  = 3'b010,
    PAS_NEXT  = 3'b011,
    PAS_DONE  = 3'b100
  } pas_state_e;
endpackage

// file: hdl/pas_result_reg.sv
`timescale 1ns/10ps
// one channel of the double buffer: holding stage plus host-visible stage
module pas_result_reg
  import pas_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              loadHold,
  input  wire logic [DATA_W-1:0] holdIn,
  input  wire logic              publish,
  output logic [DATA_W-1:0]      result
);
  logic [DATA_W-1:0] hold_q;
  logic [DATA_W-1:0] hold_d;
  logic [DATA_W-1:0] res_d;

  // first stage catches each conversion, second stage moves on publish only
  always_comb begin
    hold_d = (ce && loadHold) ? holdIn : hold_q;
    res_d  = (ce && publish) ? hold_q : result;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_q <= '0;
      result <= '0;
    end else begin
      hold_q <= hold_d;
      result <= res_d;
    end
  end
endmodule

// file: hdl/pas_sequencer.sv
`timescale 1ns/10ps
module pas_sequencer
  import pas_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                ext_convert_n,
  input  wire logic                shiftBusy,
  input  wire logic [DATA_W-1:0]   adcCode,
  output logic [CH_W-1:0]          muxChannel,
  output logic                     muxDiff,
  output logic                     sampleHold,
  output logic                     napEnable,
  output logic                     result_ready_n
);
  pas_state_e        state_q, state_d;
  logic [CH_W-1:0]   chan_q, chan_d;
  logic [TMR_W-1:0]  tmr_q, tmr_d;
  logic [TMR_W-1:0]  pulse_q, pulse_d;
  logic              mode_q, mode_d;
  logic              flag_q, flag_d;
  logic              pend_q, pend_d;
  logic [1:0]        rate_q, rate_d;
  logic [15:0]       en_q, en_d;
  logic [1:0]        diff_q, diff_d;
  logic [31:0]       prdata_d;
  logic              pready_d, pslverr_d;
  logic              readyN_d, hold_d, nap_d, mdiff_d;
  logic [CH_W-1:0]   mch_d;
  logic              cnvSync, cnvPrev_q, busySync;
  logic              wrAcc, rdAcc, extTrig, softTrig, stopCyc, modeChg, rdResult;
  logic              publish, lastCh, anyEn;
  logic [CH_W-1:0]   firstCh, nextCh;
  logic [TMR_W-1:0]  acqCyc;
  logic [CHANNELS-1:0] loadVec;
  logic [DATA_W-1:0] resArr [CHANNELS];
  logic [DATA_W-1:0] codeFmt;
  logic [CHANNELS*DATA_W-1:0] resFlat;

  pas_sync u_cnv (.clock(clock), .rst(rst), .ce(ce), .din(ext_convert_n), .dout(cnvSync));
  pas_sync #(.RST_VAL(1'b0)) u_busy (.clock(clock), .rst(rst), .ce(ce), .din(shiftBusy), .dout(busySync));

  // apb decode; one wait-free access phase
  assign wrAcc    = psel && penable && pwrite;
  assign rdAcc    = psel && penable && !pwrite;
  assign rdResult = rdAcc && (paddr >= ADDR_RESULT0);
  assign extTrig  = cnvPrev_q && !cnvSync;
  assign softTrig = wrAcc && (paddr == ADDR_CFG0) && pwdata[B_TRIG];
  assign modeChg  = wrAcc && (paddr == ADDR_CFG0) && (pwdata[B_MODE] != mode_q);
  assign stopCyc  = modeChg
                 || (wrAcc && (paddr == ADDR_CHSEL0 || paddr == ADDR_CHSEL1
                     || paddr == ADDR_THRESH));

  // scan for first enabled channel and next after the current one
  always_comb begin
    firstCh = '0;
    nextCh  = '0;
    lastCh  = 1'b1;
    anyEn   = |en_q;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (en_q[i]) begin
        firstCh = CH_W'(i);
      end
    end
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (en_q[i] && CH_W'(i) > chan_q) begin
        nextCh = CH_W'(i);
        lastCh = 1'b0;
      end
    end
  end

  // acquisition time from rate code; code 0 keeps the 2 us cycle
  always_comb begin
    case (rate_q)
      2'b00:   acqCyc = TMR_W'(ACQ0_CYC);
      2'b01:   acqCyc = TMR_W'(ACQ1_CYC);
      2'b10:   acqCyc = TMR_W'(ACQ2_CYC);
      default: acqCyc = TMR_W'(ACQ3_CYC);
    endcase
  end

  // differential pairs report twos complement, others straight binary
  always_comb begin
    codeFmt = adcCode;
    if (muxDiff) begin
      codeFmt = {~adcCode[DATA_W-1], adcCode[DATA_W-2:0]};
    end
  end

  // sequencer state; the publish pending bit survives aborts on purpose
  always_comb begin
    state_d = state_q;
    chan_d  = chan_q;
    tmr_d   = tmr_q;
    pend_d  = pend_q;
    loadVec = '0;
    publish = 1'b0;
    if (pend_q && !busySync) begin
      publish = 1'b1;
      pend_d  = 1'b0;
    end
    case (state_q)
      PAS_IDLE: ;
      PAS_ACQ: begin
        if (tmr_q == '0) begin
          state_d = PAS_CONV;
          tmr_d   = TMR_W'(CONV_CYC - 1);
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      PAS_CONV: begin
        if (tmr_q == '0) begin
          loadVec[chan_q] = 1'b1;
          state_d = lastCh ? PAS_DONE : PAS_NEXT;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      PAS_NEXT: begin
        chan_d  = nextCh;
        state_d = PAS_ACQ;
        tmr_d   = acqCyc - 1'b1;
      end
      PAS_DONE: begin
        pend_d  = 1'b1;
        chan_d  = firstCh;
        tmr_d   = acqCyc - 1'b1;
        state_d = mode_q ? PAS_ACQ : PAS_IDLE;
      end
      default: state_d = PAS_IDLE;
    endcase
    if (stopCyc) begin
      state_d = PAS_IDLE;
    end else if ((extTrig || softTrig) && anyEn) begin
      state_d = PAS_ACQ;
      chan_d  = firstCh;
      tmr_d   = acqCyc - 1'b1;
    end
  end

  // registers, handshake flag and ready pulse
  always_comb begin
    mode_d  = mode_q;
    rate_d  = rate_q;
    en_d    = en_q;
    diff_d  = diff_q;
    flag_d  = flag_q;
    pulse_d = (pulse_q != '0) ? pulse_q - 1'b1 : pulse_q;
    if (wrAcc && paddr == ADDR_CFG0) mode_d = pwdata[B_MODE];
    if (wrAcc && paddr == ADDR_CFG1) rate_d = pwdata[B_RATE_LO +: 2];
    if (wrAcc && paddr == ADDR_CHSEL0) diff_d = pwdata[B_DIFF23:B_DIFF01];
    if (wrAcc && paddr == ADDR_CHSEL1) en_d = pwdata[15:0];
    if (rdResult || extTrig) flag_d = 1'b0;
    if (publish && !mode_q) flag_d = 1'b1;                                   // set wins over the read or trigger clear
    if (mode_d) flag_d = 1'b0;                                               // clear as auto mode begins
    if (publish && mode_q) pulse_d = TMR_W'(PULSE_CYC);
    readyN_d = !(flag_d || pulse_d != '0);
    hold_d  = (state_d == PAS_CONV);
    nap_d   = (rate_q != 2'b00) && (state_d == PAS_IDLE || state_d == PAS_ACQ);
    mch_d   = chan_d;
    mdiff_d = (chan_d < CH_W'(NAP_STEPS)) && diff_q[chan_d[1]];
  end

  // apb read mux and answer
  always_comb begin
    prdata_d  = '0;
    pready_d  = psel && !penable;
    pslverr_d = 1'b0;
    if (psel && !penable && !pwrite) begin
      if (paddr >= ADDR_RESULT0) begin
        prdata_d = {20'h0_0000, resArr[paddr[5:2]]};
      end else begin
        case (paddr)
          ADDR_CFG0:   prdata_d = {29'h0, flag_q, 1'b0, mode_q};
          ADDR_CFG1:   prdata_d = {30'h0, rate_q};
          ADDR_CHSEL0: prdata_d = {30'h0, diff_q};
          ADDR_CHSEL1: prdata_d = {16'h0000, en_q};
          ADDR_THRESH: prdata_d = '0;
          ADDR_STATUS: prdata_d = {30'h0, state_q != PAS_IDLE, busySync};
          default:     pslverr_d = 1'b1;
        endcase
      end
    end else if (psel && !penable) begin
      pslverr_d = !(paddr <= ADDR_STATUS);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q        <= PAS_IDLE;
      chan_q         <= '0;
      tmr_q          <= '0;
      pulse_q        <= '0;
      pend_q         <= 1'b0;
      mode_q         <= 1'b0;
      flag_q         <= 1'b0;
      rate_q         <= CFG1_RESET[1:0];
      en_q           <= CHSEL_RESET;
      diff_q         <= 2'b00;
      cnvPrev_q      <= 1'b1;
      prdata         <= '0;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      result_ready_n <= 1'b1;
      sampleHold     <= 1'b0;
      napEnable      <= 1'b0;
      muxChannel     <= '0;
      muxDiff        <= 1'b0;
    end else if (ce) begin
      state_q        <= state_d;
      chan_q         <= chan_d;
      tmr_q          <= tmr_d;
      pulse_q        <= pulse_d;
      pend_q         <= pend_d;
      mode_q         <= mode_d;
      flag_q         <= flag_d;
      rate_q         <= rate_d;
      en_q           <= en_d;
      diff_q         <= diff_d;
      cnvPrev_q      <= cnvSync;
      prdata         <= prdata_d;
      pready         <= pready_d;
      pslverr        <= pslverr_d;
      result_ready_n <= readyN_d;
      sampleHold     <= hold_d;
      napEnable      <= nap_d;
      muxChannel     <= mch_d;
      muxDiff        <= mdiff_d;
    end
  end

  // one double-buffer cell per channel
  for (genvar g = 0; g < CHANNELS; g++) begin : g_res
    pas_result_reg u_res (
      .clock    (clock),
      .rst      (rst),
      .ce       (ce),
      .loadHold (loadVec[g]),
      .holdIn   (codeFmt),
      .publish  (publish),
      .result   (resArr[g])
    );
    assign resFlat[g*DATA_W +: DATA_W] = resArr[g];                          // flat copy for the hold-off check
  end

  property p_trig_restart;
    @(posedge clock) disable iff (rst)
    (ce && extTrig && !stopCyc && anyEn) |=> (state_q == PAS_ACQ && chan_q == firstCh);
  endproperty
  a_trig_restart: assert property (p_trig_restart) else $error("trigger did not restart");

  property p_stop;
    @(posedge clock) disable iff (rst)
    (ce && stopCyc) |=> (state_q == PAS_IDLE);
  endproperty
  a_stop: assert property (p_stop) else $error("cycle not stopped");

  property p_no_publish_busy;
    @(posedge clock) disable iff (rst)
    (ce && busySync) |=> $stable(resFlat);
  endproperty
  a_no_publish_busy: assert property (p_no_publish_busy) else $error("publish during shift");

  property p_auto_flag;
    @(posedge clock) disable iff (rst)
    mode_q |-> !flag_q;
  endproperty
  a_auto_flag: assert property (p_auto_flag) else $error("flag set in auto mode");

  property p_direct_flag;
    @(posedge clock) disable iff (rst)
    (ce && publish && !mode_q && !modeChg) |=> (flag_q && !result_ready_n);
  endproperty
  a_direct_flag: assert property (p_direct_flag) else $error("direct ready missing");

  property p_direct_idle;
    @(posedge clock) disable iff (rst)
    (ce && state_q == PAS_DONE && !mode_q && !stopCyc && !extTrig && !softTrig) |=> state_q == PAS_IDLE;
  endproperty
  a_direct_idle: assert property (p_direct_idle) else $error("direct mode kept running");

  property p_auto_loop;
    @(posedge clock) disable iff (rst)
    (ce && state_q == PAS_DONE && mode_q && !stopCyc) |=> state_q == PAS_ACQ;
  endproperty
  a_auto_loop: assert property (p_auto_loop) else $error("auto mode stopped");

  property p_pend_kept;
    @(posedge clock) disable iff (rst)
    (ce && pend_q && busySync) |=> pend_q;
  endproperty
  a_pend_kept: assert property (p_pend_kept) else $error("blocked publish lost");
endmodule

// file: hdl/pas_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for a pin level
module pas_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  logic meta_d;
  logic dout_d;

  // reset to the pin's idle level, so that no false edge follows reset
  always_comb begin
    meta_d = ce ? din : meta_q;
    dout_d = ce ? meta_q : dout;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      dout   <= dout_d;
    end
  end
endmodule

// file: testbench/pas_adc_model.sv
`timescale 1ns/10ps
// stand-in for the converter core and for the serial shifter on the host side
module pas_adc_model
  import pas_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [CH_W-1:0]   muxChannel,
  input  wire logic              sampleHold,
  input  wire logic              busyReq,
  output logic [DATA_W-1:0]      adcCode,
  output logic                   shiftBusy
);
  // each channel gives its own code; outside a conversion the code is inverted
  // so that a sample taken at the wrong moment shows up as a wrong result
  assign adcCode = sampleHold ? {muxChannel, 8'hA5} : ~{muxChannel, 8'hA5};

  // a host read holds the shifter busy for as long as the bench asks
  always_ff @(posedge clock) begin
    shiftBusy <= busyReq;
  end
endmodule

// file: testbench/pas_sequencer_test.sv
`timescale 1ns/10ps
module pas_sequencer_test;
  import pas_pkg::*;
  typedef struct packed {
    logic [15:0] mask;
    logic [3:0]  ch;
    logic [31:0] val;
  } pas_row_s;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic              extConvertN = 1'b1;
  logic              busyReq = 1'b0;
  logic              ce = 1'b1;
  logic [31:0]       prdata;
  logic [31:0]       q;
  logic              pready;
  logic              pslverr;
  logic              err;
  logic              shiftBusy;
  logic [DATA_W-1:0] adcCode;
  logic [CH_W-1:0]   muxChannel;
  logic              muxDiff;
  logic              sampleHold;
  logic              napEnable;
  logic              resultReadyN;
  int                errors = 0;
  int                n_checks = 0;
  int                cyc = 0;
  int                n;
  // channel mask, channel read back, expected result
  pas_row_s          rows [3] = '{'{16'h0001, 4'h0, 32'h0A5}, '{16'h0C00, 4'hB, 32'hBA5},
                                  '{16'h8001, 4'hF, 32'hFA5}};

  pas_sequencer dut (.clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_convert_n(extConvertN), .shiftBusy(shiftBusy), .adcCode(adcCode), .muxChannel(muxChannel),
    .muxDiff(muxDiff), .sampleHold(sampleHold), .napEnable(napEnable), .result_ready_n(resultReadyN));
  pas_adc_model adc (.clock(clock), .muxChannel(muxChannel), .sampleHold(sampleHold), .busyReq(busyReq),
    .adcCode(adcCode), .shiftBusy(shiftBusy));

  // free-running clock
  always #4 clock = ~clock;

  task report_and_stop;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // a hang counts as an error and ends through the same report as a normal run, so it fails
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      report_and_stop();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one transfer; the request stands until pready is seen at a rising edge,
  // then one idle edge passes so that back-to-back calls never overlap
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // wait for result_ready_n (sel 0) or the mux channel (sel 1) to reach v
  task waitFor(input logic sel, input logic [3:0] v, input int lim);
    int i;
    i = 0;
    do begin
      @(negedge clock);
      i++;
    end while ((sel ? muxChannel : {3'h0, resultReadyN}) !== v && i < lim);
    chk(sel ? muxChannel : {3'h0, resultReadyN}, v);
    @(posedge clock);
  endtask

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk({resultReadyN, pready, sampleHold}, 3'b100);
    @(posedge clock);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q[B_RUNNING], 1'b0);
    // direct mode, soft trigger, one row per channel set
    foreach (rows[i]) begin
      apb(1'b1, ADDR_CHSEL1, {16'h0, rows[i].mask});
      apb(1'b1, ADDR_CFG0, 32'h2);
      waitFor(1'b0, 4'h0, 6000);
      apb(1'b0, ADDR_CFG0, 32'h0);
      chk(q[B_FLAG], 1'b1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(q[B_RUNNING], 1'b0);
      apb(1'b0, ADDR_RESULT0 + {2'b00, rows[i].ch, 2'b00}, 32'h0);
      chk(q, rows[i].val);
      waitFor(1'b0, 4'h1, 4);
    end
    // pin trigger, then a second falling edge clears the ready level
    apb(1'b1, ADDR_CHSEL1, 32'h4);
    extConvertN <= 1'b0;
    waitFor(1'b0, 4'h0, 6000);
    extConvertN <= 1'b1;
    repeat (4) @(posedge clock);
    extConvertN <= 1'b0;
    waitFor(1'b0, 4'h1, 8);
    apb(1'b0, ADDR_RESULT0 + 8'h08, 32'h0);
    chk(q, 32'h2A5);
    // restart in mid-sequence, then rewrites stop the cycle
    apb(1'b1, ADDR_CHSEL1, 32'h6);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q[B_RUNNING], 1'b0);
    apb(1'b1, ADDR_CFG0, 32'h2);
    waitFor(1'b1, 4'h2, 1000);
    // clock enable low: the acquisition must not run on into the conversion
    ce <= 1'b0;
    repeat (60) @(negedge clock);
    chk({27'h0, sampleHold, muxChannel}, 32'h2);
    @(posedge clock);
    ce <= 1'b1;
    apb(1'b1, ADDR_CFG0, 32'h2);
    waitFor(1'b1, 4'h1, 8);
    apb(1'b1, ADDR_THRESH, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q[B_RUNNING], 1'b0);
    // a host read in progress holds back the publish
    apb(1'b1, ADDR_CHSEL1, 32'h8);
    busyReq <= 1'b1;
    apb(1'b1, ADDR_CFG0, 32'h2);
    repeat (ACQ3_CYC + CONV_CYC) @(posedge clock);
    chk(resultReadyN, 1'b1);
    apb(1'b0, ADDR_RESULT0 + 8'h0C, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, ADDR_CFG0, 32'h2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q[1:0], 2'b11);
    busyReq <= 1'b0;
    waitFor(1'b0, 4'h0, 100);
    apb(1'b0, ADDR_RESULT0 + 8'h0C, 32'h0);
    chk(q, 32'h3A5);
    // auto mode: mode first, trigger in a later write
    apb(1'b1, ADDR_CHSEL1, 32'h1);
    apb(1'b1, ADDR_CFG0, 32'h1);
    apb(1'b1, ADDR_CFG0, 32'h3);
    waitFor(1'b0, 4'h0, 6000);
    n = 1;
    @(negedge clock);
    while (resultReadyN === 1'b0 && n < 300) begin
      n++;
      @(negedge clock);
    end
    chk(n, PULSE_CYC);
    @(posedge clock);
    apb(1'b0, ADDR_CFG0, 32'h0);
    chk(q[B_FLAG], 1'b0);
    waitFor(1'b0, 4'h0, 6000);
    apb(1'b1, ADDR_CFG0, 32'h2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q[B_RUNNING], 1'b0);
    waitFor(1'b0, 4'h1, 200);
    // differential pair 0-1 in direct mode, then a nap rate, then reset mid-run
    apb(1'b1, ADDR_CHSEL0, 32'h1);
    apb(1'b1, ADDR_CHSEL1, 32'h1);
    apb(1'b1, ADDR_CFG0, 32'h2);
    chk(muxDiff, 1'b1);
    waitFor(1'b0, 4'h0, 6000);
    apb(1'b0, ADDR_RESULT0, 32'h0);
    chk(q, 32'h8A5); // offset code with its top bit inverted
    apb(1'b1, ADDR_CFG1, 32'h1);
    @(negedge clock);
    chk(napEnable, 1'b1);
    @(posedge clock);
    apb(1'b1, ADDR_CFG0, 32'h2);
    repeat (20) @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk({resultReadyN, napEnable, sampleHold, muxDiff}, 4'b1000);
    @(posedge clock);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(q[1:0], 2'b00);
    apb(1'b0, ADDR_RESULT0, 32'h0);
    chk(q, 32'h0);
    report_and_stop();
  end
endmodule
